// >>> core/wdt_timer.sv
// Behaviour
// [R1] Count clock is the crystal input, divided by 256 when the divide bit is set.
// [R2] In test mode the divide bit is ignored; the undivided crystal clock counts.
// [R3] Enable bit 7 stops counting at 0 and lets it run at 1.
// [R4] Interrupt-enable bit 6 gates the interrupt output toward the controller.
// [R5] Interval bits 5:4 select 2^14, 2^16, 2^18 or 2^20 watchdog clocks.
// [R6] Reset time-out follows interrupt time-out by a parameterised 1024 watchdog clocks.
// [R7] Every time-out sets interrupt flag bit 3, enabled or not.
// [R8] Writing 0 leaves the interrupt flag; writing 1 clears it.
// [R9] Reset flag bit 2 is set when the watchdog issues a chip reset.
// [R10] With reset-enable 0 the watchdog never touches the reset flag.
// [R11] Reset-enable bit 1 turns the chip-reset function on or off.
// [R12] Writing 1 to restart bit 0 clears the count; the bit reads back 0.
// [R13] A missed restart raises the interrupt when interrupt-enable is set.
// [R14] Chip reset follows the time-out only with reset-enable set.
// [R15] Interrupt request is an active-high level for controller channel 1.
// [R16] Chip reset is held for 15 watchdog clocks.
// [R17] An up-counter advances per watchdog clock and matches the selected power of two.
`timescale 1ns/1ns
module wdt_timer
  import wdt_pkg::*;
#(
  parameter logic [20:0] RESET_DELAY = WDT_RESET_DELAY_DEF
)(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xtal_clk_in,
  output logic             wd_interrupt_request,
  output logic             wd_chip_reset,
  output logic             wd_irq
);

  logic                 xtal_meta;
  logic                 xtal_sync;
  logic                 xtal_prev;
  logic                 xtal_edge;
  logic                 wd_tick;
  logic                 wd_clock_divide_select;
  logic                 wd_enable_bit;
  logic                 wd_interrupt_enable;
  logic [1:0]           wd_interval_select;
  logic                 wd_interrupt_flag;
  logic                 wd_reset_flag;
  logic                 wd_reset_enable;
  logic                 wd_test_mode;
  logic [1:0]           ev_status;
  logic [1:0]           ev_mask;
  wdt_state_t           state;
  wdt_state_t           next_state;
  logic [WDT_CNT_W-1:0] cnt;
  logic [WDT_CNT_W-1:0] next_cnt;
  logic [WDT_CNT_W-1:0] cnt_inc;
  logic [WDT_CNT_W-1:0] limit;
  logic                 timeout_evt;
  logic                 reset_evt;
  logic                 wr_acc;
  logic                 rd_setup;
  logic                 hit_ctrl;
  logic                 hit_aux;
  logic                 hit_istat;
  logic                 hit_imask;
  logic                 hit_any;
  logic                 ctrl_wr_lo;
  logic                 ctrl_wr_hi;
  logic                 restart;
  logic [31:0]          rd_mux;

  // Crystal input crosses into sys_clk through two flops
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      xtal_meta <= xtal_clk_in;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  // Rising crystal edge, seen only after the synchroniser
  assign xtal_edge = xtal_sync & ~xtal_prev;

  // Watchdog clock tick, divider bypassed in test mode
  wdt_prescale u_prescale (
    .sys_clk (sys_clk),
    .reset   (reset),
    .clk_en  (clk_en),
    .edge_in (xtal_edge),
    .divide  (wd_clock_divide_select & ~wd_test_mode), // see [R1] see [R2]
    .tick    (wd_tick)
  );

  // Bus decode; zero wait states
  assign pready     = 1'b1;
  assign wr_acc     = psel & penable & pwrite;
  assign rd_setup   = psel & ~penable & ~pwrite;
  assign hit_ctrl   = (paddr == WDT_CTRL_ADDR);
  assign hit_aux    = (paddr == WDT_AUX_ADDR);
  assign hit_istat  = (paddr == WDT_ISTAT_ADDR);
  assign hit_imask  = (paddr == WDT_IMASK_ADDR);
  assign hit_any    = hit_ctrl | hit_aux | hit_istat | hit_imask;
  assign pslverr    = psel & penable & ~hit_any;
  assign ctrl_wr_lo = wr_acc & hit_ctrl & pstrb[0];
  assign ctrl_wr_hi = wr_acc & hit_ctrl & pstrb[1];
  assign restart    = ctrl_wr_lo & pwdata[WDT_RESTART_BIT]; // see [R12]

  // Control fields written by software
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wd_clock_divide_select <= WDT_CTRL_RESET[WDT_DIV_BIT];
      wd_enable_bit          <= WDT_CTRL_RESET[WDT_EN_BIT];
      wd_interrupt_enable    <= WDT_CTRL_RESET[WDT_IE_BIT];
      wd_interval_select     <= WDT_CTRL_RESET[WDT_IS_LSB+1:WDT_IS_LSB];
      wd_reset_enable        <= WDT_CTRL_RESET[WDT_RE_BIT];
    end
    else if (clk_en)
    begin
      if (ctrl_wr_hi)
      begin
        wd_clock_divide_select <= pwdata[WDT_DIV_BIT]; // see [R1]
      end
      if (ctrl_wr_lo)
      begin
        wd_enable_bit       <= pwdata[WDT_EN_BIT]; // see [R3]
        wd_interrupt_enable <= pwdata[WDT_IE_BIT]; // see [R4]
        wd_interval_select  <= pwdata[WDT_IS_LSB+1:WDT_IS_LSB]; // see [R5]
        wd_reset_enable     <= pwdata[WDT_RE_BIT]; // see [R11]
      end
    end
  end

  // Test mode, interrupt mask
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wd_test_mode <= 1'b0;
      ev_mask      <= WDT_EV_RESET;
    end
    else if (clk_en)
    begin
      if (wr_acc & hit_aux & pstrb[0])
      begin
        wd_test_mode <= pwdata[WDT_TEST_BIT]; // see [R2]
      end
      if (wr_acc & hit_imask & pstrb[0])
      begin
        ev_mask <= pwdata[1:0];
      end
    end
  end

  // Selected interrupt time-out as a power of two
  assign limit   = WDT_CNT_W'(1) << (WDT_IS_BASE_EXP + 2 * wd_interval_select); // see [R5]
  assign cnt_inc = cnt + WDT_CNT_W'(1);

  // Phase sequencing: count, wait for reset, hold reset
  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    timeout_evt = 1'b0;
    reset_evt   = 1'b0;
    if (restart)
    begin
      next_state = WDT_ST_COUNT; // see [R12]
      next_cnt   = '0;
    end
    else if (wd_enable_bit && wd_tick) // see [R3] see [R17]
    begin
      case (state)
        WDT_ST_COUNT:
        begin
          if (cnt_inc == limit)
          begin
            timeout_evt = 1'b1; // see [R7] see [R13]
            next_state  = WDT_ST_WAIT;
            next_cnt    = '0;
          end
          else
          begin
            next_cnt = cnt_inc;
          end
        end
        WDT_ST_WAIT:
        begin
          if (cnt_inc == RESET_DELAY) // see [R6]
          begin
            next_cnt = '0;
            if (wd_reset_enable)
            begin
              reset_evt  = 1'b1; // see [R14]
              next_state = WDT_ST_RESET;
            end
            else
            begin
              next_state = WDT_ST_COUNT;
            end
          end
          else
          begin
            next_cnt = cnt_inc;
          end
        end
        WDT_ST_RESET:
        begin
          if (cnt_inc == WDT_RESET_HOLD) // see [R16]
          begin
            next_state = WDT_ST_COUNT;
            next_cnt   = '0;
          end
          else
          begin
            next_cnt = cnt_inc;
          end
        end
        default:
        begin
          next_state = WDT_ST_COUNT;
          next_cnt   = '0;
        end
      endcase
    end
  end

  // Phase and count registers
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state <= WDT_ST_COUNT;
      cnt   <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Chip reset drive, straight from the phase flop
  assign wd_chip_reset = (state == WDT_ST_RESET); // see [R16]

  // Sticky flags; a set in the same cycle beats a clear
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wd_interrupt_flag <= WDT_CTRL_RESET[WDT_IF_BIT];
      wd_reset_flag     <= WDT_CTRL_RESET[WDT_RF_BIT];
    end
    else if (clk_en)
    begin
      if (timeout_evt)
      begin
        wd_interrupt_flag <= 1'b1; // see [R7]
      end
      else if (ctrl_wr_lo && pwdata[WDT_IF_BIT])
      begin
        wd_interrupt_flag <= 1'b0; // see [R8]
      end
      if (reset_evt)
      begin
        wd_reset_flag <= 1'b1; // see [R9] see [R10]
      end
      else if (ctrl_wr_lo && pwdata[WDT_RF_BIT])
      begin
        wd_reset_flag <= 1'b0; // see [R9]
      end
    end
  end

  // Event status, write one to clear, set wins
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ev_status <= WDT_EV_RESET;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == WDT_EV_TIMEOUT && timeout_evt) || (i == WDT_EV_CHIPRST && reset_evt))
        begin
          ev_status[i] <= 1'b1;
        end
        else if (wr_acc && hit_istat && pstrb[0] && pwdata[i])
        begin
          ev_status[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt outputs
  assign wd_interrupt_request = wd_interrupt_flag & wd_interrupt_enable; // see [R4] see [R15]
  assign wd_irq               = |(ev_status & ev_mask);

  // Read data multiplexer
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_mux[WDT_DIV_BIT]                 = wd_clock_divide_select;
      rd_mux[WDT_EN_BIT]                  = wd_enable_bit;
      rd_mux[WDT_IE_BIT]                  = wd_interrupt_enable;
      rd_mux[WDT_IS_LSB+1:WDT_IS_LSB]     = wd_interval_select;
      rd_mux[WDT_IF_BIT]                  = wd_interrupt_flag;
      rd_mux[WDT_RF_BIT]                  = wd_reset_flag;
      rd_mux[WDT_RE_BIT]                  = wd_reset_enable;
    end
    else if (hit_aux)
    begin
      rd_mux[WDT_TEST_BIT] = wd_test_mode;
    end
    else if (hit_istat)
    begin
      rd_mux[1:0] = ev_status;
    end
    else if (hit_imask)
    begin
      rd_mux[1:0] = ev_mask;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (clk_en && rd_setup)
    begin
      prdata <= rd_mux;
    end
  end

  // Checks
  sequence count_expires_s;
    clk_en && !restart && wd_enable_bit && wd_tick && state == WDT_ST_COUNT && cnt_inc == limit;
  endsequence

  sequence wait_expires_s;
    clk_en && !restart && wd_enable_bit && wd_tick && state == WDT_ST_WAIT && cnt_inc == RESET_DELAY;
  endsequence

  sequence flag_keep_write_s;
    clk_en && wd_interrupt_flag && ctrl_wr_lo && !pwdata[WDT_IF_BIT];
  endsequence

  flag_set_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R7]
    count_expires_s |=> wd_interrupt_flag && state == WDT_ST_WAIT && cnt == '0)
    else $error("time-out did not set the interrupt flag");

  flag_keep_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R8]
    flag_keep_write_s |=> wd_interrupt_flag)
    else $error("writing zero cleared the interrupt flag");

  flag_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R8]
    clk_en && ctrl_wr_lo && pwdata[WDT_IF_BIT] && !timeout_evt |=> !wd_interrupt_flag)
    else $error("writing one did not clear the interrupt flag");

  rst_after_wait_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R6]
    wait_expires_s ##0 wd_reset_enable[*1] |=> wd_chip_reset && wd_reset_flag)
    else $error("reset did not follow the wait period");

  rst_gated_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R11]
    $rose(wd_chip_reset) |-> $past(wd_reset_enable))
    else $error("chip reset issued with reset disabled");

  rflag_guard_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R10]
    !wd_reset_enable && !ctrl_wr_lo |=> $stable(wd_reset_flag))
    else $error("reset flag changed while reset disabled");

  restart_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R12]
    clk_en && restart |=> cnt == '0 && state == WDT_ST_COUNT && !prdata[WDT_RESTART_BIT])
    else $error("restart did not clear the count");

  hold_len_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R16]
    wd_chip_reset |-> cnt < WDT_RESET_HOLD)
    else $error("chip reset held too long");

  stop_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R3]
    clk_en && !wd_enable_bit && !restart |=> $stable(cnt) && $stable(state))
    else $error("counter moved while disabled");

  irq_gate_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R4]
    $rose(wd_interrupt_request) |-> wd_interrupt_enable && wd_interrupt_flag)
    else $error("interrupt request without enable");

  undiv_tick_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R2]
    clk_en && xtal_edge && (wd_test_mode || !wd_clock_divide_select) |=> wd_tick)
    else $error("undivided crystal edge gave no tick");

endmodule : wdt_timer

// >>> core/wdt_pkg.sv
package wdt_pkg;

  // Register byte addresses on the peripheral bus
  localparam logic [31:0] WDT_CTRL_ADDR   = 32'hb800_101c;
  localparam logic [31:0] WDT_AUX_ADDR    = 32'hb800_1060;
  localparam logic [31:0] WDT_ISTAT_ADDR  = 32'hb800_1064;
  localparam logic [31:0] WDT_IMASK_ADDR  = 32'hb800_1068;

  // Control register field positions
  localparam int unsigned WDT_DIV_BIT     = 10;
  localparam int unsigned WDT_EN_BIT      = 7;
  localparam int unsigned WDT_IE_BIT      = 6;
  localparam int unsigned WDT_IS_LSB      = 4;
  localparam int unsigned WDT_IF_BIT      = 3;
  localparam int unsigned WDT_RF_BIT      = 2;
  localparam int unsigned WDT_RE_BIT      = 1;
  localparam int unsigned WDT_RESTART_BIT = 0;

  // Auxiliary control, interrupt status and mask fields
  localparam int unsigned WDT_TEST_BIT    = 0;
  localparam int unsigned WDT_EV_TIMEOUT  = 0;
  localparam int unsigned WDT_EV_CHIPRST  = 1;

  // Values after reset
  localparam logic [31:0] WDT_CTRL_RESET  = 32'h0000_0000;
  localparam logic [1:0]  WDT_EV_RESET    = 2'h0;

  // Counts in watchdog clocks; the prescaler's last count in crystal edges
  localparam int unsigned WDT_CNT_W       = 21;
  localparam int unsigned WDT_IS_BASE_EXP = 14;
  localparam logic [20:0] WDT_RESET_DELAY_DEF = 21'h0_0400;
  localparam logic [20:0] WDT_RESET_HOLD  = 21'h0_000f;
  localparam logic [7:0]  WDT_PRESCALE_LAST = 8'hff;

  // Counting phases
  typedef enum logic [2:0] {
    WDT_ST_COUNT = 3'b001,
    WDT_ST_WAIT  = 3'b010,
    WDT_ST_RESET = 3'b100
  } wdt_state_t;

endpackage : wdt_pkg

// >>> core/wdt_prescale.sv
`timescale 1ns/1ns
module wdt_prescale
  import wdt_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic edge_in,
  input  wire logic divide,
  output logic      tick
);

  logic [7:0] count;

  // One tick per crystal edge, or per 256 edges when dividing
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count <= 8'h00;
      tick  <= 1'b0;
    end
    else if (clk_en)
    begin
      tick <= 1'b0;
      if (edge_in)
      begin
        if (!divide)
        begin
          tick  <= 1'b1;
          count <= 8'h00;
        end
        else
        begin
          count <= count + 8'h01;
          if (count == WDT_PRESCALE_LAST)
          begin
            tick <= 1'b1;
          end
        end
      end
    end
  end

  // Divided mode: no tick unless the prescaler wrapped
  div_gap_a: assert property (@(posedge sys_clk) disable iff (reset) // see [R1]
    clk_en && edge_in && divide && count != WDT_PRESCALE_LAST |=> !tick)
    else $error("divided clock ticked before 256 edges");

endmodule : wdt_prescale

// >>> sim/wdt_irq_model.sv
`timescale 1ns/1ns
// Interrupt controller channel 1 and chip reset length monitor
module wdt_irq_model
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       xtal_clk_in,
  input  wire logic       wd_interrupt_request,
  input  wire logic       wd_chip_reset,
  output logic            chan1_seen,
  output logic      [7:0] rst_len,
  output logic      [7:0] rst_events
);
  logic       xtal_q;
  logic       rst_q;
  logic [7:0] run_len;

  // Channel 1 takes a high level; remember any request
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      chan1_seen <= 1'b0;
    else if (wd_interrupt_request === 1'b1)
      chan1_seen <= 1'b1;
  end

  // Length of each chip reset in crystal periods
  always_ff @(posedge sys_clk)
  begin
    xtal_q <= xtal_clk_in;
    rst_q  <= wd_chip_reset;
    if (reset)
    begin
      run_len    <= 8'h00;
      rst_len    <= 8'h00;
      rst_events <= 8'h00;
    end
    else if (wd_chip_reset === 1'b1)
      run_len <= run_len + 8'(xtal_clk_in && !xtal_q);
    else if (rst_q === 1'b1)
    begin
      rst_len    <= run_len;
      rst_events <= rst_events + 8'h01;
      run_len    <= 8'h00;
    end
  end
endmodule : wdt_irq_model

// >>> sim/watchdog_timer_bench.sv
`timescale 1ns/1ns
module watchdog_timer_bench
  import wdt_pkg::*;
;
  typedef struct packed {logic [31:0] addr; logic [31:0] wdata; logic [31:0] rexp; logic [31:0] err;} wdt_row_t;

  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        xtal_clk_in = 1'b0;
  logic        xph = 1'b0;
  logic        ticking = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] err;
  logic        pready;
  logic        pslverr;
  logic        wd_interrupt_request;
  logic        wd_chip_reset;
  logic        wd_irq;
  logic        chan1_seen;
  logic [7:0]  rst_len;
  logic [7:0]  rst_events;
  int          n_fail = 0;
  int          n_checks = 0;
  int          ticks = 0;
  int          b;
  logic [31:0] regs [4] = '{WDT_CTRL_ADDR, WDT_AUX_ADDR, WDT_ISTAT_ADDR, WDT_IMASK_ADDR};
  wdt_row_t    rows [8] = '{
    '{WDT_CTRL_ADDR, 32'h0000_0431, 32'h0000_0430, 32'h0000_0000},
    '{WDT_CTRL_ADDR, 32'h0000_0062, 32'h0000_0062, 32'h0000_0000},
    '{WDT_CTRL_ADDR, 32'h0000_00d0, 32'h0000_00d0, 32'h0000_0000},
    '{WDT_CTRL_ADDR, 32'hffff_fb0c, 32'h0000_0000, 32'h0000_0000},
    '{WDT_AUX_ADDR, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000},
    '{WDT_IMASK_ADDR, 32'h0000_0003, 32'h0000_0003, 32'h0000_0000},
    '{WDT_ISTAT_ADDR, 32'h0000_0003, 32'h0000_0000, 32'h0000_0000},
    '{32'hb800_1020, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0001}};

  wdt_timer #(.RESET_DELAY(21'h0_0004)) wdt_timer_i (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk_in(xtal_clk_in), .wd_interrupt_request(wd_interrupt_request), .wd_chip_reset(wd_chip_reset),
    .wd_irq(wd_irq));

  wdt_irq_model wdt_irq_model_i (
    .sys_clk(sys_clk), .reset(reset), .xtal_clk_in(xtal_clk_in), .wd_interrupt_request(wd_interrupt_request),
    .wd_chip_reset(wd_chip_reset), .chan1_seen(chan1_seen), .rst_len(rst_len), .rst_events(rst_events));

  // Clock and a crystal at a quarter of its rate; rises are counted while enabled
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    xph <= ~xph;
    if (xph)
      xtal_clk_in <= ~xtal_clk_in;
    if (xph && !xtal_clk_in && ticking)
      ticks <= ticks + 1;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [31:0] a, input logic [31:0] d, input logic w);
    int k;
    k = 0;
    @(posedge sys_clk);
    paddr  <= a;
    pwdata <= d;
    pwrite <= w;
    psel   <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      n_fail++;
    rd = prdata;
    err = 32'(pslverr);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bounded waits for crystal rises or an output level
  task automatic run_to(input int n);
    int k;
    k = 0;
    while (ticks < n && k < 70000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 70000)
    begin
      n_fail++;
      close_out();
    end
  endtask : run_to

  task automatic wait_for(input logic sel, input logic lvl);
    int k;
    k = 0;
    while ((sel ? wd_chip_reset : wd_irq) !== lvl && k < 400)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 400)
    begin
      n_fail++;
      close_out();
    end
  endtask : wait_for

  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // Register rows: write, then read back
    foreach (rows[i])
    begin
      apb(rows[i].addr, rows[i].wdata, 1'b1);
      chk(err, rows[i].err);
      apb(rows[i].addr, 32'h0000_0000, 1'b0);
      chk(rd, rows[i].rexp);
    end
    // Second reset in mid-run clears every register and the interrupt and reset outputs
    reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    chk({wd_interrupt_request, wd_chip_reset, wd_irq}, 32'h0000_0000);
    foreach (regs[i])
    begin
      apb(regs[i], 32'h0000_0000, 1'b0);
      chk(rd, 32'h0000_0000);
    end
    // Timeout: test mode overrides divide, restart mid-count, pause while disabled
    apb(WDT_AUX_ADDR, 32'h0000_0001, 1'b1);
    apb(WDT_IMASK_ADDR, 32'h0000_0003, 1'b1);
    apb(WDT_CTRL_ADDR, 32'h0000_0483, 1'b1);
    ticking <= 1'b1;
    run_to(2000);
    apb(WDT_CTRL_ADDR, 32'h0000_0483, 1'b1);
    b = ticks;
    apb(WDT_CTRL_ADDR, 32'h0000_0402, 1'b1);
    ticking <= 1'b0;
    repeat (2000) @(posedge sys_clk);
    apb(WDT_CTRL_ADDR, 32'h0000_0482, 1'b1);
    ticking <= 1'b1;
    run_to(b + 16380);
    apb(WDT_CTRL_ADDR, 32'h0000_0000, 1'b0);
    chk(rd & 32'h0000_0008, 32'h0000_0000);
    wait_for(1'b0, 1'b1);
    chk(32'((ticks - b) inside {[16381:16389]}), 32'h0000_0001);
    chk(32'(wd_interrupt_request), 32'h0000_0000);
    b = ticks;
    apb(WDT_CTRL_ADDR, 32'h0000_04c2, 1'b1);
    #1;
    chk(32'(wd_interrupt_request), 32'h0000_0001);
    wait_for(1'b1, 1'b1);
    chk(32'((ticks - b) inside {[2:6]}), 32'h0000_0001);
    wait_for(1'b1, 1'b0);
    #1;
    chk(32'(rst_len inside {[14:16]}), 32'h0000_0001);
    chk({chan1_seen, rst_events}, 32'h0000_0101);
    apb(WDT_CTRL_ADDR, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_04ce);
    apb(WDT_ISTAT_ADDR, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0003);
    // Event interrupt masked, unmasked, then cleared
    apb(WDT_IMASK_ADDR, 32'h0000_0000, 1'b1);
    #1;
    chk(32'(wd_irq), 32'h0000_0000);
    apb(WDT_IMASK_ADDR, 32'h0000_0003, 1'b1);
    #1;
    chk(32'(wd_irq), 32'h0000_0001);
    apb(WDT_CTRL_ADDR, 32'h0000_044e, 1'b1);
    #1;
    chk(32'(wd_interrupt_request), 32'h0000_0000);
    apb(WDT_CTRL_ADDR, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0442);
    apb(WDT_ISTAT_ADDR, 32'h0000_0003, 1'b1);
    #1;
    chk(32'(wd_irq), 32'h0000_0000);
    close_out();
  end

  // Hang guard
  initial
  begin
    #1_000_000;
    n_fail++;
    close_out();
  end
endmodule : watchdog_timer_bench
